// ---- testbench/cfb_exec_bench.sv ----
// self-checking bench for the flag, bit and transfer executor
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR at %0t: got %0h, expected %0h", $time, got, exp); end end
module cfb_exec_bench;
  import cfb_pkg::*;

  logic            sys_clk_i;
  logic            resetn_i;
  logic            op_valid_i;
  cfb_op_t         op_i;
  logic            op_ready_o;
  logic            op_done_o;
  logic [PC_W-1:0] pc_o;
  logic [7:0]      status_o;
  logic [7:0]      bus_addr_i;
  logic [7:0]      bus_wdata_i;
  logic            bus_wr_i;
  logic            bus_rd_i;
  logic [7:0]      bus_rdata_o;
  int              n_errors;
  int              comparisons;

  cfb_exec cfb_exec_i (
    .sys_clk_i  (sys_clk_i),
    .resetn_i   (resetn_i),
    .op_valid_i (op_valid_i),
    .op_i       (op_i),
    .op_ready_o (op_ready_o),
    .op_done_o  (op_done_o),
    .pc_o       (pc_o),
    .status_o   (status_o),
    .bus_addr_i (bus_addr_i),
    .bus_wdata_i(bus_wdata_i),
    .bus_wr_i   (bus_wr_i),
    .bus_rd_i   (bus_rd_i),
    .bus_rdata_o(bus_rdata_o)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [7:0] rf(input logic [7:0] n);
    return BUS_RF_BASE + n;
  endfunction : rf

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    bus_wr_i    <= 1'b1;
    bus_addr_i  <= a;
    bus_wdata_i <= d;
    @(posedge sys_clk_i);
    bus_wr_i    <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    bus_rd_i   <= 1'b1;
    bus_addr_i <= a;
    @(posedge sys_clk_i);
    bus_rd_i   <= 1'b0;
    #1;
    `CHECK(bus_rdata_o, e)
  endtask : rchk

  task automatic do_op(input cfb_opc_t c, input logic [4:0] rd, input logic [4:0] rr, input logic [2:0] b,
                       input logic [7:0] imm, input logic [1:0] p, input int cyc);
    int   n;
    logic rdy1;
    @(posedge sys_clk_i);
    op_valid_i <= 1'b1;
    op_i       <= '{opc: c, rd: rd, rr: rr, bitn: b, imm: imm, ptr: p};
    @(posedge sys_clk_i);
    op_valid_i <= 1'b0;
    rdy1 = 1'b1;
    // a one-cycle op shows its done pulse right after the take edge
    for (n = 1; n <= 8; n++)
    begin
      #1;
      if (n == 1)
        rdy1 = op_ready_o;
      if (op_done_o === 1'b1)
        break;
      @(posedge sys_clk_i);
    end
    if (n > 8)
    begin
      n_errors++;
      $display("ERROR at %0t: operation never finished", $time);
      finish_test();
    end
    `CHECK(n, cyc)
    `CHECK(rdy1, (cyc == 1) ? 1'b1 : 1'b0)
  endtask : do_op

  task automatic test_reset();
    `CHECK(pc_o, PC_RST)
    `CHECK(status_o, SR_RST)
    rchk(rf(8'h05), REG_RST);
    rchk(BUS_IO_BASE + 8'h03, 8'h00);
    rchk(8'h28, 8'h00);
    wr(BUS_SR_ADDR, 8'h5a);
    rchk(BUS_SR_ADDR, 8'h5a);
    @(posedge sys_clk_i);
    #1;
    `CHECK(bus_rdata_o, 8'h00)
    wr(BUS_PC_LO, 8'h77);
    `CHECK(pc_o, PC_RST)
    wr(BUS_DM_BASE, 8'h12);
    rchk(BUS_DM_BASE, 8'h00);
    $display("test reset done");
  endtask : test_reset

  task automatic test_branch();
    cfb_opc_t    ops [6] = '{OP_BRANCH_TRANSFER_FLAG_SET, OP_BRANCH_TRANSFER_FLAG_CLEAR, OP_BRANCH_OVERFLOW_SET,
                             OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED};
    int          fl [6]  = '{FLG_T, FLG_T, FLG_V, FLG_V, FLG_I, FLG_I};
    logic [15:0] p0;
    logic [15:0] ep;
    logic [7:0]  sr;
    logic [7:0]  imm;
    logic        tk;
    for (int i = 0; i < 6; i++)
      for (int v = 0; v < 2; v++)
      begin
        sr  = 8'(v) << fl[i];
        wr(BUS_SR_ADDR, sr);
        // alternate a forward and a backward offset
        imm = i[0] ? 8'h7d : 8'h05;
        p0  = pc_o;
        tk  = (v == (i[0] ? 0 : 1));
        ep  = tk ? p0 + {{9{imm[6]}}, imm[6:0]} + 16'h0001 : p0 + 16'h0001;
        do_op(ops[i], 5'h00, 5'h00, 3'd0, imm, 2'd0, tk ? 2 : 1);
        `CHECK(pc_o, ep)
        `CHECK(status_o, sr)
      end
    $display("test branch done");
  endtask : test_branch

  task automatic test_io();
    wr(BUS_IO_BASE + 8'h07, 8'h5a);
    wr(BUS_SR_ADDR, 8'h3c);
    do_op(OP_IO_BIT_FORCE_ONE, 5'h07, 5'h00, 3'd0, 8'h00, 2'd0, 2);
    rchk(BUS_IO_BASE + 8'h07, 8'h5b);
    do_op(OP_IO_BIT_FORCE_ZERO, 5'h07, 5'h00, 3'd6, 8'h00, 2'd0, 2);
    rchk(BUS_IO_BASE + 8'h07, 8'h1b);
    rchk(BUS_IO_BASE + 8'h06, 8'h00);
    `CHECK(status_o, 8'h3c)
    $display("test io done");
  endtask : test_io

  task automatic sh(input cfb_opc_t c, input logic [4:0] r, input logic [2:0] b, input logic [7:0] v,
                    input logic [7:0] s, input logic [7:0] ev, input logic [7:0] es);
    wr(rf({3'b000, r}), v);
    wr(BUS_SR_ADDR, s);
    do_op(c, r, r, b, 8'h00, 2'd0, 1);
    rchk(rf({3'b000, r}), ev);
    `CHECK(status_o, es)
  endtask : sh

  task automatic test_bits();
    sh(OP_ROTATE_RIGHT_CARRY, 5'd5, 3'd0, 8'h81, 8'h00, 8'h40, 8'h09);
    sh(OP_ROTATE_RIGHT_CARRY, 5'd6, 3'd0, 8'h00, 8'h11, 8'h80, 8'h1c);
    sh(OP_ROTATE_RIGHT_CARRY, 5'd7, 3'd0, 8'h01, 8'h00, 8'h00, 8'h0b);
    sh(OP_ARITH_SHIFT_RIGHT, 5'd8, 3'd0, 8'h81, 8'h00, 8'hc0, 8'h05);
    sh(OP_NIBBLE_SWAP, 5'd9, 3'd0, 8'h3c, 8'h2a, 8'hc3, 8'h2a);
    sh(OP_BIT_TO_TRANSFER_FLAG, 5'd10, 3'd5, 8'h20, 8'h00, 8'h20, 8'h40);
    sh(OP_BIT_TO_TRANSFER_FLAG, 5'd13, 3'd0, 8'hfe, 8'hff, 8'hfe, 8'hbf);
    sh(OP_TRANSFER_FLAG_TO_BIT, 5'd11, 3'd3, 8'hff, 8'h00, 8'hf7, 8'h00);
    sh(OP_TRANSFER_FLAG_TO_BIT, 5'd12, 3'd7, 8'h00, 8'h41, 8'h80, 8'h41);
    $display("test bits done");
  endtask : test_bits

  task automatic test_flags();
    cfb_opc_t   fo [8] = '{OP_HALF_CARRY_FORCE_ONE, OP_HALF_CARRY_FORCE_ZERO, OP_TRANSFER_FORCE_ONE,
                           OP_TRANSFER_FORCE_ZERO, OP_SIGNED_FLAG_FORCE_ONE, OP_SIGNED_FLAG_FORCE_ZERO,
                           OP_OVERFLOW_FORCE_ONE, OP_OVERFLOW_FORCE_ZERO};
    int         ff [8] = '{FLG_H, FLG_H, FLG_T, FLG_T, FLG_S, FLG_S, FLG_V, FLG_V};
    logic [7:0] sr;
    logic [7:0] ex;
    for (int i = 0; i < 8; i++)
    begin
      sr = i[0] ? 8'hff : 8'h00;
      ex = i[0] ? (sr & ~(8'h01 << ff[i])) : (8'h01 << ff[i]);
      wr(BUS_SR_ADDR, sr);
      do_op(fo[i], 5'h00, 5'h00, 3'd0, 8'h00, 2'd0, 1);
      `CHECK(status_o, ex)
    end
    $display("test flags done");
  endtask : test_flags

  task automatic test_loads();
    wr(BUS_SR_ADDR, 8'h2a);
    wr(BUS_DM_BASE + 8'h10, 8'ha7);
    wr(BUS_DM_BASE + 8'h0f, 8'h3e);
    wr(BUS_DM_BASE + 8'h3f, 8'h99);
    wr(rf(8'h1a), 8'h10);
    wr(rf(8'h1b), 8'h00);
    do_op(OP_LOAD_POST_INC, 5'd3, 5'd0, 3'd0, 8'h00, 2'd0, 2);
    rchk(rf(8'h03), 8'ha7);
    rchk(rf(8'h1a), 8'h11);
    wr(rf(8'h1c), 8'h10);
    wr(rf(8'h1d), 8'h00);
    do_op(OP_LOAD_PRE_DEC, 5'd4, 5'd0, 3'd0, 8'h00, 2'd1, 2);
    rchk(rf(8'h04), 8'h3e);
    rchk(rf(8'h1c), 8'h0f);
    // borrow out of the low pointer byte
    wr(rf(8'h1e), 8'h00);
    wr(rf(8'h1f), 8'h01);
    do_op(OP_LOAD_PRE_DEC, 5'd13, 5'd0, 3'd0, 8'h00, 2'd2, 2);
    rchk(rf(8'h0d), 8'h99);
    rchk(rf(8'h1e), 8'hff);
    rchk(rf(8'h1f), 8'h00);
    wr(rf(8'h1a), 8'hff);
    do_op(OP_LOAD_POST_INC, 5'd14, 5'd0, 3'd0, 8'h00, 2'd0, 2);
    rchk(rf(8'h0e), 8'h99);
    rchk(rf(8'h1a), 8'h00);
    rchk(rf(8'h1b), 8'h01);
    `CHECK(status_o, 8'h2a)
    $display("test loads done");
  endtask : test_loads

  task automatic test_moves();
    logic [15:0] p0;
    wr(BUS_SR_ADDR, 8'h55);
    wr(rf(8'h0e), 8'h11);
    wr(rf(8'h12), 8'hab);
    wr(rf(8'h13), 8'hcd);
    p0 = pc_o;
    do_op(OP_MOVE, 5'd15, 5'd14, 3'd0, 8'h00, 2'd0, 1);
    do_op(OP_PAIR_COPY, 5'd17, 5'd19, 3'd0, 8'h00, 2'd0, 1);
    do_op(OP_LOAD_CONSTANT, 5'd20, 5'd0, 3'd0, 8'he4, 2'd0, 1);
    do_op(OP_NOP, 5'd0, 5'd0, 3'd0, 8'h00, 2'd0, 1);
    `CHECK(pc_o, p0 + 16'h0004)
    rchk(rf(8'h0f), 8'h11);
    rchk(rf(8'h10), 8'hab);
    rchk(rf(8'h11), 8'hcd);
    rchk(rf(8'h14), 8'he4);
    `CHECK(status_o, 8'h55)
    $display("test moves done");
  endtask : test_moves

  initial
  begin
    n_errors    = 0;
    comparisons = 0;
    resetn_i    = 1'b0;
    op_valid_i  = 1'b0;
    op_i        = '0;
    bus_addr_i  = 8'h00;
    bus_wdata_i = 8'h00;
    bus_wr_i    = 1'b0;
    bus_rd_i    = 1'b0;
    repeat (6) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    test_reset();
    test_branch();
    test_io();
    test_bits();
    test_flags();
    test_loads();
    test_moves();
    finish_test();
  end

endmodule : cfb_exec_bench
`default_nettype wire

// ---- verilog/cfb_dmem.sv ----
// data byte memory: one write port, one read port with registered data
`timescale 1ns/100ps
`default_nettype none
module cfb_dmem
  import cfb_pkg::*;
(
  input  wire logic                       sys_clk_i,
  input  wire logic                       wr_en_i,
  input  wire logic [cfb_pkg::DM_AW-1:0]  wr_addr_i,
  input  wire logic [cfb_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic [cfb_pkg::DM_AW-1:0]  rd_addr_i,
  output logic      [cfb_pkg::DATA_W-1:0] rd_data_o
);

  logic [DATA_W-1:0] mem_ff [DM_DEPTH];
  logic [DATA_W-1:0] rd_data_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (wr_en_i)
    begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
    rd_data_ff <= mem_ff[rd_addr_i];
  end

  assign rd_data_o = rd_data_ff;

endmodule : cfb_dmem
`default_nettype wire

// ---- verilog/cfb_exec.sv ----
// executor for flag branches, bit ops, shifts, flag ops, moves and pointer loads
//
// Notes on behaviour
// (RL1) branch on transfer flag, 1 or 2 cycles
// (RL2) branch on overflow flag, flags untouched
// (RL3) branch on interrupt enable, 1 or 2 cycles
// (RL4) set I/O bit, two cycles
// (RL5) clear I/O bit, two cycles
// (RL6) rotate right through carry, updates Z C N V
// (RL7) copy register bit into transfer flag
// (RL8) copy transfer flag into register bit
// (RL9) set/clear half carry and transfer flags
// (RL10) set/clear signed test flag
// (RL11) set/clear overflow flag
// (RL12) pointer load then increment, two cycles
// (RL13) pointer decrement then load, two cycles
// (RL14) move, pair copy, constant load: one cycle
// (RL15) arithmetic shift right and nibble swap
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module cfb_exec
  import cfb_pkg::*;
(
  input  wire logic                       sys_clk_i,
  input  wire logic                       resetn_i,
  input  wire logic                       op_valid_i,
  input  wire cfb_pkg::cfb_op_t           op_i,
  output logic                            op_ready_o,
  output logic                            op_done_o,
  output logic      [cfb_pkg::PC_W-1:0]   pc_o,
  output logic      [cfb_pkg::DATA_W-1:0] status_o,
  input  wire logic [7:0]                 bus_addr_i,
  input  wire logic [7:0]                 bus_wdata_i,
  input  wire logic                       bus_wr_i,
  input  wire logic                       bus_rd_i,
  output logic      [7:0]                 bus_rdata_o
);

  typedef enum logic {ST_IDLE, ST_SECOND} cfb_state_t;

  function automatic logic [4:0] ptr_lo_idx(input logic [1:0] sel);
    ptr_lo_idx = (sel == 2'h0) ? PTR_X_LO : (sel == 2'h1) ? PTR_Y_LO : PTR_Z_LO;
  endfunction : ptr_lo_idx

  function automatic logic [4:0] ptr_hi_idx(input logic [1:0] sel);
    ptr_hi_idx = ptr_lo_idx(sel) | 5'h01;
  endfunction : ptr_hi_idx

  function automatic logic [7:0] bit_put(input logic [7:0] val, input logic [2:0] idx, input logic b);
    logic [7:0] r;
    r      = val;
    r[idx] = b;
    bit_put = r;
  endfunction : bit_put

  // Z C N V after a right shift; S is left alone
  function automatic logic [7:0] shift_flags(input logic [7:0] sr, input logic [7:0] res, input logic cout);
    logic [7:0] r;
    r        = sr;
    r[FLG_Z] = (res == 8'h00);
    r[FLG_C] = cout;
    r[FLG_N] = res[7];
    r[FLG_V] = res[7] ^ cout;
    shift_flags = r;
  endfunction : shift_flags

  logic [7:0]  rf_ff [NUM_REGS];
  logic [7:0]  io_ff [NUM_IO];
  logic [7:0]  sr_ff, nxt_sr;
  logic [15:0] pc_ff, nxt_pc;
  logic [15:0] ptr_ff;
  cfb_state_t  st_ff, nxt_st;
  cfb_op_t     op_ff;
  logic        done_ff, nxt_done;
  logic [7:0]  rdata_ff;

  // decode of the incoming operation
  wire cfb_opc_t    opc       = op_i.opc;
  wire logic        accept    = op_valid_i && (st_ff == ST_IDLE);
  wire logic [7:0]  rd_val    = rf_ff[op_i.rd];
  wire logic [7:0]  rr_val    = rf_ff[op_i.rr];
  wire logic [7:0]  io_val    = io_ff[op_i.rd[2:0]];
  wire logic [15:0] ptr_now   = {rf_ff[ptr_hi_idx(op_i.ptr)], rf_ff[ptr_lo_idx(op_i.ptr)]};
  wire logic [15:0] ptr_dec   = ptr_now - 16'h0001;
  wire logic [15:0] ptr_cur   = {rf_ff[ptr_hi_idx(op_ff.ptr)], rf_ff[ptr_lo_idx(op_ff.ptr)]};
  wire logic [7:0]  dm_rdata;
  wire logic [5:0]  dm_raddr  = (opc == OP_LOAD_PRE_DEC) ? ptr_dec[5:0] : ptr_now[5:0];
  wire logic        is_load   = (opc == OP_LOAD_POST_INC) || (opc == OP_LOAD_PRE_DEC);
  wire logic        is_io     = (opc == OP_IO_BIT_FORCE_ONE) || (opc == OP_IO_BIT_FORCE_ZERO);

  wire logic br_t  = (opc == OP_BRANCH_TRANSFER_FLAG_SET) || (opc == OP_BRANCH_TRANSFER_FLAG_CLEAR);
  wire logic br_v  = (opc == OP_BRANCH_OVERFLOW_SET) || (opc == OP_BRANCH_OVERFLOW_CLEAR);
  wire logic br_i  = (opc == OP_BRANCH_IRQ_ENABLED) || (opc == OP_BRANCH_IRQ_DISABLED);
  wire logic br_is = br_t || br_v || br_i;
  wire logic br_want = (opc == OP_BRANCH_TRANSFER_FLAG_SET) || (opc == OP_BRANCH_OVERFLOW_SET)
                       || (opc == OP_BRANCH_IRQ_ENABLED);
  wire logic br_flag = br_t ? sr_ff[FLG_T] : br_v ? sr_ff[FLG_V] : sr_ff[FLG_I];
  // (RL1) (RL2) (RL3) branch condition select
  wire logic        br_taken  = br_is && (br_flag == br_want);
  wire logic [15:0] br_target = pc_ff + {{9{op_i.imm[6]}}, op_i.imm[6:0]} + 16'h0001;

  wire logic [7:0] ror_res  = {sr_ff[FLG_C], rd_val[7:1]};
  wire logic [7:0] asr_res  = {rd_val[7], rd_val[7:1]};
  wire logic [7:0] swap_res = {rd_val[3:0], rd_val[7:4]};

  // register port decode
  wire logic bus_rf = bus_addr_i < BUS_IO_BASE;
  wire logic bus_io = (bus_addr_i >= BUS_IO_BASE) && (bus_addr_i < BUS_IO_BASE + 8'(NUM_IO));
  wire logic bus_dm = (bus_addr_i >= BUS_DM_BASE) && (bus_addr_i < BUS_DM_BASE + 8'(DM_DEPTH));
  wire logic [7:0] bus_rd_mux =
      bus_rf                      ? rf_ff[bus_addr_i[4:0]] :
      bus_io                      ? io_ff[bus_addr_i[2:0]] :
      (bus_addr_i == BUS_SR_ADDR) ? sr_ff :
      (bus_addr_i == BUS_PC_LO)   ? pc_ff[7:0] :
      (bus_addr_i == BUS_PC_HI)   ? pc_ff[15:8] : 8'h00;

  // core write ports: A (destination), B (pair high), P (pointer pair)
  logic       wa_en, wb_en, wp_en, wio_en;
  logic [4:0] wa_idx;
  logic [7:0] wa_dat, wb_dat, wio_dat;
  logic [15:0] wp_val;

  always_comb
  begin
    nxt_st   = st_ff;
    nxt_pc   = pc_ff;
    nxt_sr   = sr_ff;
    nxt_done = 1'b0;
    wa_en    = 1'b0;
    wa_idx   = op_i.rd;
    wa_dat   = 8'h00;
    wb_en    = 1'b0;
    wb_dat   = 8'h00;
    wp_en    = 1'b0;
    wp_val   = 16'h0000;
    wio_en   = 1'b0;
    wio_dat  = 8'h00;
    if (st_ff == ST_SECOND)
    begin
      nxt_st   = ST_IDLE;
      nxt_done = 1'b1;
      if (op_ff.opc == OP_LOAD_POST_INC || op_ff.opc == OP_LOAD_PRE_DEC)
      begin
        wa_en  = 1'b1;
        wa_idx = op_ff.rd;
        wa_dat = dm_rdata;
        wp_en  = 1'b1;
        // (RL12) (RL13) pointer write back
        wp_val = (op_ff.opc == OP_LOAD_POST_INC) ? ptr_ff + 16'h0001 : ptr_ff - 16'h0001;
      end
    end
    else if (accept)
    begin
      nxt_pc   = pc_ff + 16'h0001;
      nxt_done = 1'b1;
      if ((br_is && br_taken) || is_io || is_load)
      begin
        nxt_st   = ST_SECOND;
        nxt_done = 1'b0;
      end
      unique case (opc)
        OP_BRANCH_TRANSFER_FLAG_SET, OP_BRANCH_TRANSFER_FLAG_CLEAR, OP_BRANCH_OVERFLOW_SET,
        OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IRQ_ENABLED, OP_BRANCH_IRQ_DISABLED:
        begin
          if (br_taken)
          begin
            nxt_pc = br_target;
          end
        end
        // (RL4) (RL5) single I/O bit update
        OP_IO_BIT_FORCE_ONE, OP_IO_BIT_FORCE_ZERO:
        begin
          wio_en  = 1'b1;
          wio_dat = bit_put(io_val, op_i.bitn, opc == OP_IO_BIT_FORCE_ONE);
        end
        // (RL6) rotate through carry
        OP_ROTATE_RIGHT_CARRY:
        begin
          wa_en  = 1'b1;
          wa_dat = ror_res;
          nxt_sr = shift_flags(sr_ff, ror_res, rd_val[0]);
        end
        // (RL15) shift and swap
        OP_ARITH_SHIFT_RIGHT:
        begin
          wa_en  = 1'b1;
          wa_dat = asr_res;
          nxt_sr = shift_flags(sr_ff, asr_res, rd_val[0]);
        end
        OP_NIBBLE_SWAP:
        begin
          wa_en  = 1'b1;
          wa_dat = swap_res;
        end
        // (RL7) register bit to flag
        OP_BIT_TO_TRANSFER_FLAG: nxt_sr[FLG_T] = rr_val[op_i.bitn];
        // (RL8) flag to register bit
        OP_TRANSFER_FLAG_TO_BIT:
        begin
          wa_en  = 1'b1;
          wa_dat = bit_put(rd_val, op_i.bitn, sr_ff[FLG_T]);
        end
        // (RL9) half carry and transfer flags
        OP_HALF_CARRY_FORCE_ONE:   nxt_sr[FLG_H] = 1'b1;
        OP_HALF_CARRY_FORCE_ZERO:  nxt_sr[FLG_H] = 1'b0;
        OP_TRANSFER_FORCE_ONE:     nxt_sr[FLG_T] = 1'b1;
        OP_TRANSFER_FORCE_ZERO:    nxt_sr[FLG_T] = 1'b0;
        // (RL10) signed test flag
        OP_SIGNED_FLAG_FORCE_ONE:  nxt_sr[FLG_S] = 1'b1;
        OP_SIGNED_FLAG_FORCE_ZERO: nxt_sr[FLG_S] = 1'b0;
        // (RL11) overflow flag
        OP_OVERFLOW_FORCE_ONE:     nxt_sr[FLG_V] = 1'b1;
        OP_OVERFLOW_FORCE_ZERO:    nxt_sr[FLG_V] = 1'b0;
        // (RL14) plain transfers
        OP_MOVE:
        begin
          wa_en  = 1'b1;
          wa_dat = rr_val;
        end
        OP_PAIR_COPY:
        begin
          wa_en  = 1'b1;
          wa_idx = {op_i.rd[4:1], 1'b0};
          wa_dat = rf_ff[{op_i.rr[4:1], 1'b0}];
          wb_en  = 1'b1;
          wb_dat = rf_ff[{op_i.rr[4:1], 1'b1}];
        end
        OP_LOAD_CONSTANT:
        begin
          wa_en  = 1'b1;
          wa_dat = op_i.imm;
        end
        OP_LOAD_POST_INC, OP_LOAD_PRE_DEC, OP_NOP:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_ff    <= ST_IDLE;
      pc_ff    <= PC_RST;
      done_ff  <= 1'b0;
      op_ff    <= '0;
      ptr_ff   <= 16'h0000;
      rdata_ff <= 8'h00;
    end
    else
    begin
      st_ff    <= nxt_st;
      pc_ff    <= nxt_pc;
      done_ff  <= nxt_done;
      rdata_ff <= bus_rd_i ? bus_rd_mux : 8'h00;
      if (accept)
      begin
        op_ff  <= op_i;
        ptr_ff <= ptr_now;
      end
    end
  end

  // a software write in the same cycle lands after the core's update
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sr_ff <= SR_RST;
      for (int i = 0; i < NUM_REGS; i++) rf_ff[i] <= REG_RST;
      for (int i = 0; i < NUM_IO; i++) io_ff[i] <= REG_RST;
    end
    else
    begin
      sr_ff <= (bus_wr_i && bus_addr_i == BUS_SR_ADDR) ? bus_wdata_i : nxt_sr;
      for (int i = 0; i < NUM_REGS; i++)
      begin
        if (wp_en && 5'(i) == ptr_lo_idx(op_ff.ptr)) rf_ff[i] <= wp_val[7:0];
        if (wp_en && 5'(i) == ptr_hi_idx(op_ff.ptr)) rf_ff[i] <= wp_val[15:8];
        if (wb_en && 5'(i) == (wa_idx | 5'h01)) rf_ff[i] <= wb_dat;
        if (wa_en && 5'(i) == wa_idx) rf_ff[i] <= wa_dat;
        if (bus_wr_i && bus_rf && 5'(i) == bus_addr_i[4:0]) rf_ff[i] <= bus_wdata_i;
      end
      for (int i = 0; i < NUM_IO; i++)
      begin
        if (wio_en && 3'(i) == op_i.rd[2:0]) io_ff[i] <= wio_dat;
        if (bus_wr_i && bus_io && 3'(i) == bus_addr_i[2:0]) io_ff[i] <= bus_wdata_i;
      end
    end
  end

  cfb_dmem cfb_dmem_i (
    .sys_clk_i (sys_clk_i),
    .wr_en_i   (bus_wr_i && bus_dm),
    .wr_addr_i (bus_addr_i[5:0]),
    .wr_data_i (bus_wdata_i),
    .rd_addr_i (dm_raddr),
    .rd_data_o (dm_rdata)
  );

  assign op_ready_o  = (st_ff == ST_IDLE);
  assign op_done_o   = done_ff;
  assign pc_o        = pc_ff;
  assign status_o    = sr_ff;
  assign bus_rdata_o = rdata_ff;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_two_cycle;
    !op_ready_o ##1 (op_ready_o && op_done_o);
  endsequence

  sequence s_quiet_accept;
    accept && !bus_wr_i;
  endsequence

  property p_branch_taken;
    s_quiet_accept ##0 (br_is && br_taken) |=> (pc_ff == $past(br_target)) ##0 s_two_cycle;
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("taken branch target or timing wrong"); // RL1

  property p_branch_fall;
    s_quiet_accept ##0 (br_is && !br_taken) |=> pc_ff == $past(pc_ff) + 16'h0001 && op_ready_o && op_done_o
                                                 && sr_ff == $past(sr_ff);
  endproperty
  a_branch_fall: assert property (p_branch_fall) else $error("untaken branch not one cycle"); // RL2

  property p_irq_branch;
    s_quiet_accept ##0 (opc == OP_BRANCH_IRQ_ENABLED) ##0 sr_ff[FLG_I] |=> pc_ff == $past(br_target);
  endproperty
  a_irq_branch: assert property (p_irq_branch) else $error("interrupt branch missed"); // RL3

  property p_io_one;
    s_quiet_accept ##0 (opc == OP_IO_BIT_FORCE_ONE) |=> io_ff[op_ff.rd[2:0]][op_ff.bitn] && sr_ff == $past(sr_ff)
                                                       ##0 s_two_cycle;
  endproperty
  a_io_one: assert property (p_io_one) else $error("io bit not set in two cycles"); // RL4

  property p_io_zero;
    s_quiet_accept ##0 (opc == OP_IO_BIT_FORCE_ZERO) |=> !io_ff[op_ff.rd[2:0]][op_ff.bitn] ##0 s_two_cycle;
  endproperty
  a_io_zero: assert property (p_io_zero) else $error("io bit not cleared"); // RL5

  property p_rotate;
    s_quiet_accept ##0 (opc == OP_ROTATE_RIGHT_CARRY) |=> rf_ff[op_ff.rd] == $past(ror_res)
                                                         && sr_ff[FLG_C] == $past(rd_val[0]);
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate result or carry wrong"); // RL6

  property p_bit_store;
    s_quiet_accept ##0 (opc == OP_BIT_TO_TRANSFER_FLAG) |=> sr_ff[FLG_T] == $past(rr_val[op_i.bitn])
                                                           && sr_ff[5:0] == $past(sr_ff[5:0]);
  endproperty
  a_bit_store: assert property (p_bit_store) else $error("transfer flag not loaded"); // RL7

  property p_bit_load;
    s_quiet_accept ##0 (opc == OP_TRANSFER_FLAG_TO_BIT) |=> rf_ff[op_ff.rd][op_ff.bitn] == $past(sr_ff[FLG_T])
                                                           && sr_ff == $past(sr_ff);
  endproperty
  a_bit_load: assert property (p_bit_load) else $error("register bit not loaded"); // RL8

  property p_overflow_set;
    s_quiet_accept ##0 (opc == OP_OVERFLOW_FORCE_ONE) |=> sr_ff == ($past(sr_ff) | 8'h08);
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("overflow set disturbed flags"); // RL11

  property p_load_post;
    s_quiet_accept ##0 (opc == OP_LOAD_POST_INC) ##1 !bus_wr_i |=>
      op_ready_o && op_done_o && ptr_cur == $past(ptr_ff) + 16'h0001 && rf_ff[op_ff.rd] == $past(dm_rdata);
  endproperty
  a_load_post: assert property (p_load_post) else $error("post increment load wrong"); // RL12

  property p_load_pre;
    s_quiet_accept ##0 (opc == OP_LOAD_PRE_DEC) ##1 !bus_wr_i |=>
      op_ready_o && op_done_o && ptr_cur == $past(ptr_ff) - 16'h0001 && rf_ff[op_ff.rd] == $past(dm_rdata);
  endproperty
  a_load_pre: assert property (p_load_pre) else $error("pre decrement load wrong"); // RL13

endmodule : cfb_exec
`default_nettype wire

// ---- verilog/cfb_pkg.sv ----
// shared constants and types for the flag, bit and transfer executor
package cfb_pkg;

  localparam int unsigned DATA_W   = 8;
  localparam int unsigned PC_W     = 16;
  localparam int unsigned NUM_REGS = 32;
  localparam int unsigned NUM_IO   = 8;
  localparam int unsigned DM_DEPTH = 64;
  localparam int unsigned DM_AW    = 6;

  // status flag positions
  localparam int unsigned FLG_C = 0;
  localparam int unsigned FLG_Z = 1;
  localparam int unsigned FLG_N = 2;
  localparam int unsigned FLG_V = 3;
  localparam int unsigned FLG_S = 4;
  localparam int unsigned FLG_H = 5;
  localparam int unsigned FLG_T = 6;
  localparam int unsigned FLG_I = 7;

  // reset values
  localparam logic [7:0]  SR_RST   = 8'h00;
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [7:0]  REG_RST  = 8'h00;

  // pointer pairs, low register index
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  // register port map
  localparam logic [7:0] BUS_RF_BASE = 8'h00;
  localparam logic [7:0] BUS_IO_BASE = 8'h20;
  localparam logic [7:0] BUS_SR_ADDR = 8'h30;
  localparam logic [7:0] BUS_PC_LO   = 8'h31;
  localparam logic [7:0] BUS_PC_HI   = 8'h32;
  localparam logic [7:0] BUS_DM_BASE = 8'h40;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_BRANCH_TRANSFER_FLAG_SET,
    OP_BRANCH_TRANSFER_FLAG_CLEAR,
    OP_BRANCH_OVERFLOW_SET,
    OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ENABLED,
    OP_BRANCH_IRQ_DISABLED,
    OP_IO_BIT_FORCE_ONE,
    OP_IO_BIT_FORCE_ZERO,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_SHIFT_RIGHT,
    OP_NIBBLE_SWAP,
    OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT,
    OP_HALF_CARRY_FORCE_ONE,
    OP_HALF_CARRY_FORCE_ZERO,
    OP_TRANSFER_FORCE_ONE,
    OP_TRANSFER_FORCE_ZERO,
    OP_SIGNED_FLAG_FORCE_ONE,
    OP_SIGNED_FLAG_FORCE_ZERO,
    OP_OVERFLOW_FORCE_ONE,
    OP_OVERFLOW_FORCE_ZERO,
    OP_MOVE,
    OP_PAIR_COPY,
    OP_LOAD_CONSTANT,
    OP_LOAD_POST_INC,
    OP_LOAD_PRE_DEC
  } cfb_opc_t;

  typedef struct packed {
    cfb_opc_t   opc;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bitn;
    logic [7:0] imm;
    logic [1:0] ptr;
  } cfb_op_t;

endpackage : cfb_pkg
